// >>> hdl/gxf_top.sv
// Gesture exit detection and FIFO threshold interrupt logic
// Overview of operation
// RQ1: Compare exit threshold with unmasked detector data
// RQ2: Zero threshold blocks exit; only mode clear
// RQ3: FIFO level vs code 1/4/8/16 raises interrupt
// RQ4: Mask bits drop E, W, S, N
// RQ5: Zero mask includes all four detectors
// RQ6: Mask bits combine independently
// RQ7: Exit after 1/2/4/7 consecutive gesture ends
// RQ8: End means all below; else counter clears
module gxf_top #(
	parameter int unsigned DW = 8                      // Detector data width
) (
	input  wire logic              clk,                // 100 MHz clock
	input  wire logic              rstn,               // Asynchronous reset, active low
	input  wire logic              th_wr,              // Write strobe, threshold register
	input  wire logic              cfg_wr,             // Write strobe, config register
	input  wire logic [7:0]        wr_data,            // Write data
	output logic [7:0]             gesture_exit_threshold_reg, // Threshold readback
	output logic [7:0]             gesture_exit_fifo_config,   // Config readback
	input  wire logic              gesture_engine_active,      // Mode control bit
	input  wire logic              entry_req,          // Entry request from entry logic
	input  wire logic              sample_valid,       // New directional dataset
	input  wire logic [4*DW-1:0]   directional_photodiodes,    // E,W,S,N packed
	input  wire logic [5:0]        fifo_level,         // Datasets now stored
	input  wire logic              fifo_int_en,        // FIFO interrupt enable
	output logic                   gesture_run,        // Engine inside state machine
	output logic                   gesture_exit,       // One-cycle exit pulse
	output logic [2:0]             end_count,          // Consecutive gesture-end count
	output logic                   fifo_int            // FIFO threshold interrupt level
);

	// ==================================================
	// Register file
	// ==================================================
	logic [7:0] th_q, th_d;   // Exit threshold
	logic [7:0] cfg_q, cfg_d; // Threshold, mask, persistence fields

	// Next value for host-written registers
	always_comb begin
		th_d  = th_q;
		cfg_d = cfg_q;
		if (th_wr) begin
			th_d = wr_data;
		end
		if (cfg_wr) begin
			cfg_d = wr_data;
		end
	end

	// Register storage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			th_q  <= gxf_pkg::EXIT_TH_RST;
			cfg_q <= gxf_pkg::CFG_RST;
		end else begin
			th_q  <= th_d;
			cfg_q <= cfg_d;
		end
	end

	// Field views
	logic [3:0] exit_detector_mask;       // Exit mask field
	logic [1:0] exit_persistence_setting; // Persistence code
	logic [1:0] fifo_level_threshold;     // FIFO threshold code
	assign exit_detector_mask       = cfg_q[gxf_pkg::MASK_HI:gxf_pkg::MASK_LO];
	assign exit_persistence_setting = cfg_q[gxf_pkg::PERS_HI:gxf_pkg::PERS_LO];
	assign fifo_level_threshold     = cfg_q[gxf_pkg::FIFO_TH_HI:gxf_pkg::FIFO_TH_LO];

	// ==================================================
	// Gesture-end detection
	// ==================================================
	logic end_hit; // Raw compare result

	gxf_end_detect #(
		.DW (DW)
	) u_end (
		.dir_data       (directional_photodiodes),
		.exit_mask      (exit_detector_mask),
		.exit_threshold (th_q),
		.end_hit        (end_hit)
	);

	// Persistence target decode
	logic [2:0] pers_need;
	always_comb begin
		unique case (exit_persistence_setting) // RQ7
			2'h0: pers_need = gxf_pkg::PERS_CNT_0;
			2'h1: pers_need = gxf_pkg::PERS_CNT_1;
			2'h2: pers_need = gxf_pkg::PERS_CNT_2;
			2'h3: pers_need = gxf_pkg::PERS_CNT_3;
		endcase
	end

	// ==================================================
	// Gesture state machine
	// ==================================================
	gxf_pkg::gxf_state_e st_q, st_d;
	logic [2:0]          cnt_q, cnt_d;   // Consecutive end counter
	logic                exit_q, exit_d; // Exit pulse
	logic                end_ok;         // Usable gesture end

	// Next state, counter and exit pulse
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		exit_d = 1'b0;
		// Zero threshold can never signal an end, so only mode clear leaves
		end_ok = end_hit && (th_q != gxf_pkg::EXIT_TH_OFF); // RQ2
		unique case (st_q)
			gxf_pkg::GXF_IDLE: begin
				cnt_d = 3'h0;
				if (gesture_engine_active && entry_req) begin
					st_d = gxf_pkg::GXF_RUN;
				end
			end
			gxf_pkg::GXF_RUN: begin
				if (!gesture_engine_active) begin
					// Mode cleared: leave at once, no exit pulse
					st_d  = gxf_pkg::GXF_IDLE;
					cnt_d = 3'h0;
				end else if (sample_valid) begin
					if (!end_ok) begin
						cnt_d = 3'h0; // RQ8
					end else if (cnt_q + 3'h1 >= pers_need) begin
						st_d   = gxf_pkg::GXF_IDLE; // RQ7
						cnt_d  = 3'h0;
						exit_d = 1'b1;
					end else begin
						cnt_d = cnt_q + 3'h1; // RQ7
					end
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q   <= gxf_pkg::GXF_IDLE;
			cnt_q  <= 3'h0;
			exit_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			exit_q <= exit_d;
		end
	end

	// ==================================================
	// FIFO threshold interrupt
	// ==================================================
	logic [5:0] fifo_need; // Level selected by threshold code
	logic       fint_q, fint_d;

	// Level decode and compare
	always_comb begin
		unique case (fifo_level_threshold) // RQ3
			2'h0: fifo_need = gxf_pkg::FIFO_LVL_0;
			2'h1: fifo_need = gxf_pkg::FIFO_LVL_1;
			2'h2: fifo_need = gxf_pkg::FIFO_LVL_2;
			2'h3: fifo_need = gxf_pkg::FIFO_LVL_3;
		endcase
		// Level, not sticky: drops as soon as the host drains the FIFO
		fint_d = fifo_int_en && (fifo_level >= fifo_need); // RQ3
	end

	// Interrupt register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fint_q <= 1'b0;
		end else begin
			fint_q <= fint_d;
		end
	end

	// ==================================================
	// Outputs, all from flip-flops
	// ==================================================
	assign gesture_exit_threshold_reg = th_q;
	assign gesture_exit_fifo_config   = cfg_q;
	assign gesture_run                = (st_q == gxf_pkg::GXF_RUN);
	assign gesture_exit               = exit_q;
	assign end_count                  = cnt_q;
	assign fifo_int                   = fint_q;

	// ==================================================
	// Assertions
	// ==================================================
	sequence s_run_end;
		gesture_run && gesture_engine_active && sample_valid && end_ok;
	endsequence

	zero_th_block_a: assert property (@(posedge clk) disable iff (!rstn) // RQ2
		(th_q == gxf_pkg::EXIT_TH_OFF) |=> !gesture_exit)
		else $error("exit pulse with zero threshold");

	single_exit_a: assert property (@(posedge clk) disable iff (!rstn) // RQ7
		(s_run_end and (exit_persistence_setting == 2'h0)) |=> gesture_exit && !gesture_run)
		else $error("first end did not exit with code 0");

	pers_two_a: assert property (@(posedge clk) disable iff (!rstn) // RQ7
		(s_run_end and (exit_persistence_setting == 2'h1) && (cnt_q == 3'h0)) |=>
		!gesture_exit && (end_count == 3'h1))
		else $error("code 1 exited on first end");

	count_clear_a: assert property (@(posedge clk) disable iff (!rstn) // RQ8
		(gesture_run && gesture_engine_active && sample_valid && !end_ok) |=> end_count == 3'h0)
		else $error("counter kept after non-end sample");

	exit_count_a: assert property (@(posedge clk) disable iff (!rstn) // RQ7
		gesture_exit |-> ($past(cnt_q) + 3'h1 >= $past(pers_need)))
		else $error("exit before persistence reached");

	mask_all_a: assert property (@(posedge clk) disable iff (!rstn) // RQ5
		(exit_detector_mask == 4'h0 && end_hit) |->
		(directional_photodiodes[DW-1:0] < th_q) && (directional_photodiodes[4*DW-1 -: DW] < th_q))
		else $error("detector ignored with mask clear");

	mask_drop_a: assert property (@(posedge clk) disable iff (!rstn) // RQ4
		(exit_detector_mask == 4'hF) |-> end_hit)
		else $error("masked detectors still compared");

	mask_pair_a: assert property (@(posedge clk) disable iff (!rstn) // RQ6
		(exit_detector_mask == 4'h6 && directional_photodiodes[DW-1:0] < th_q &&
		directional_photodiodes[4*DW-1 -: DW] < th_q) |-> end_hit)
		else $error("west and south not both dropped");

	fifo_int_a: assert property (@(posedge clk) disable iff (!rstn) // RQ3
		(fifo_int_en && fifo_level >= fifo_need) |=> fifo_int)
		else $error("fifo interrupt missed");

	fifo_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // RQ3
		(fifo_level < fifo_need) |=> !fifo_int)
		else $error("fifo interrupt below threshold");

endmodule

// >>> hdl/gxf_pkg.sv
// Package of constants for the gesture exit and FIFO threshold block
package gxf_pkg;

	// ==================================================
	// Register field layout
	// ==================================================
	localparam int unsigned FIFO_TH_HI   = 7;     // FIFO threshold field top bit
	localparam int unsigned FIFO_TH_LO   = 6;     // FIFO threshold field bottom bit
	localparam int unsigned MASK_HI      = 5;     // Exit mask field top bit
	localparam int unsigned MASK_LO      = 2;     // Exit mask field bottom bit
	localparam int unsigned PERS_HI      = 1;     // Persistence field top bit
	localparam int unsigned PERS_LO      = 0;     // Persistence field bottom bit

	// Mask bit positions inside the 4-bit exit mask
	localparam int unsigned MSK_EAST     = 0;
	localparam int unsigned MSK_WEST     = 1;
	localparam int unsigned MSK_SOUTH    = 2;
	localparam int unsigned MSK_NORTH    = 3;

	// ==================================================
	// Reset values
	// ==================================================
	localparam logic [7:0] EXIT_TH_RST   = 8'h00; // Exit threshold after reset
	localparam logic [7:0] CFG_RST       = 8'h00; // Mask, FIFO and persistence after reset

	// ==================================================
	// Decode tables
	// ==================================================
	localparam logic [7:0] EXIT_TH_OFF   = 8'h00; // Threshold value that blocks exit

	// FIFO level needed per threshold code
	localparam logic [5:0] FIFO_LVL_0    = 6'h01;
	localparam logic [5:0] FIFO_LVL_1    = 6'h04;
	localparam logic [5:0] FIFO_LVL_2    = 6'h08;
	localparam logic [5:0] FIFO_LVL_3    = 6'h10;

	// Consecutive gesture-end count needed per persistence code
	localparam logic [2:0] PERS_CNT_0    = 3'h1;
	localparam logic [2:0] PERS_CNT_1    = 3'h2;
	localparam logic [2:0] PERS_CNT_2    = 3'h4;
	localparam logic [2:0] PERS_CNT_3    = 3'h7;

	// Gesture engine states
	typedef enum logic [0:0] {
		GXF_IDLE = 1'b0,
		GXF_RUN  = 1'b1
	} gxf_state_e;

endpackage

// >>> hdl/gxf_end_detect.sv
// Combinational gesture-end detector over the four masked directional channels
module gxf_end_detect #(
	parameter int unsigned DW = 8              // Data width of one detector
) (
	input  wire logic [4*DW-1:0] dir_data,     // Packed channels: E,W,S,N from bit 0 up
	input  wire logic [3:0]      exit_mask,    // Set bit drops a detector
	input  wire logic [DW-1:0]   exit_threshold, // Exit threshold
	output logic                 end_hit       // All included detectors below threshold
);

	// ==================================================
	// Per-detector compare
	// ==================================================
	logic [3:0] below; // One flag per detector, forced true when masked

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ch
			// Masked channel counts as satisfied, so bits combine independently
			assign below[gi] = exit_mask[gi] | (dir_data[gi*DW +: DW] < exit_threshold); // RQ1 RQ4 RQ6
		end
	endgenerate

	// All-masked yields a hit on every sample; the threshold-zero guard is upstream
	assign end_hit = &below; // RQ5 RQ8

endmodule

// >>> tb/gxf_host_model.sv
// Host processor model that writes the two gesture exit registers
module gxf_host_model (
	input  wire logic       clk,
	output logic            th_wr,
	output logic            cfg_wr,
	output logic [7:0]      wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================
	// Idle bus
	// ==================================================
	// Strobes low at start, data bus parked
	initial begin
		th_wr = 1'b0;
		cfg_wr = 1'b0;
		wr_data = 8'h00;
	end
	// ==================================================
	// Register write
	// ==================================================
	// One-cycle strobe; released data shows the inverse so a stale value cannot pass for fresh
	task automatic write(input logic sel, input logic [7:0] val);
		@(posedge clk);
		th_wr <= ~sel;
		cfg_wr <= sel;
		wr_data <= val;
		@(posedge clk);
		th_wr <= 1'b0;
		cfg_wr <= 1'b0;
		wr_data <= ~val;
	endtask
endmodule

// >>> tb/gesture_exit_and_fifo_threshold_bench.sv
// Self-checking bench for the gesture exit and FIFO threshold block
module gesture_exit_and_fifo_threshold_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================
	// Signals
	// ==================================================
	logic        clk = 1'b0;             // 100 MHz clock
	logic        rstn = 1'b0;            // Reset, active low
	logic        th_wr, cfg_wr;          // Driven by the host model
	logic [7:0]  wr_data;                // Host write data
	logic        mode = 1'b0;            // Mode control bit
	logic        entry_req = 1'b0;       // Entry request
	logic        sample_valid = 1'b0;    // New dataset strobe
	logic        fifo_int_en = 1'b0;     // FIFO interrupt enable
	logic [5:0]  fifo_level = 6'h00;     // Stored datasets
	logic [31:0] dir_data = 32'h0;       // E,W,S,N channels
	logic [7:0]  th_rb, cfg_rb;          // Register readbacks
	logic        g_run, g_exit, f_int;   // Design results
	logic [2:0]  g_cnt;                  // Consecutive end count
	logic [7:0]  e_th = 8'h00;           // Model threshold
	logic [7:0]  e_cfg = 8'h00;          // Model config
	int          e_run = 0, e_exit = 0, e_cnt = 0, e_int = 0;
	int          lvl[4] = '{1, 4, 8, 16}; // FIFO level per code
	int          need[4] = '{1, 2, 4, 7}; // Ends needed per code
	int          error_cnt = 0;
	int          n_checks = 0;
	bit          quiet;                  // Low data phase, makes ends likely
	logic [3:0]  msk = 4'h0;             // Exit mask chosen per round
	// ==================================================
	// Clock, design and host
	// ==================================================
	always #5 clk = ~clk;
	gxf_top #(.DW(8)) i_dut (.clk(clk), .rstn(rstn), .th_wr(th_wr), .cfg_wr(cfg_wr), .wr_data(wr_data),
		.gesture_exit_threshold_reg(th_rb), .gesture_exit_fifo_config(cfg_rb), .gesture_engine_active(mode),
		.entry_req(entry_req), .sample_valid(sample_valid), .directional_photodiodes(dir_data),
		.fifo_level(fifo_level), .fifo_int_en(fifo_int_en), .gesture_run(g_run), .gesture_exit(g_exit),
		.end_count(g_cnt), .fifo_int(f_int));
	gxf_host_model i_host (.clk(clk), .th_wr(th_wr), .cfg_wr(cfg_wr), .wr_data(wr_data));
	// ==================================================
	// Reference model
	// ==================================================
	// Gesture end: threshold nonzero and every unmasked channel below it
	function automatic bit is_end(logic [31:0] d, logic [3:0] m, logic [7:0] th);
		is_end = (th != 8'h00);
		for (int k = 0; k < 4; k++)
			if (!m[k] && d[8*k +: 8] >= th) is_end = 1'b0;
	endfunction
	// Reads pre-edge inputs, since the stimulus lands by non-blocking assignment
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{e_th, e_cfg} = 16'h0000;
			e_run = 0;
			e_exit = 0;
			e_cnt = 0;
			e_int = 0;
		end else begin
			e_int = fifo_int_en && (fifo_level >= lvl[e_cfg[7:6]]);
			e_exit = 0;
			if (e_run == 0) begin
				e_run = mode && entry_req;
				e_cnt = 0;
			end else if (!mode) begin
				e_run = 0;
				e_cnt = 0;
			end else if (sample_valid) begin
				if (is_end(dir_data, e_cfg[5:2], e_th)) begin
					e_cnt++;
					if (e_cnt >= need[e_cfg[1:0]]) begin
						e_exit = 1;
						e_run = 0;
						e_cnt = 0;
					end
				end else e_cnt = 0;
			end
			if (th_wr) e_th = wr_data;
			if (cfg_wr) e_cfg = wr_data;
		end
	end
	// ==================================================
	// Comparisons
	// ==================================================
	task automatic chk_bit(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask
	task automatic chk_cnt(input logic [2:0] got, input logic [2:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: end count got %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Outputs are settled at the falling edge
	always @(negedge clk) begin
		chk_reg(th_rb, e_th, "threshold readback");
		chk_reg(cfg_rb, e_cfg, "config readback");
		chk_bit(g_run, 1'(e_run), "run");
		chk_bit(g_exit, 1'(e_exit), "exit pulse");
		chk_cnt(g_cnt, 3'(e_cnt));
		chk_bit(f_int, 1'(e_int), "fifo interrupt");
	end
	// ==================================================
	// Verdict
	// ==================================================
	task automatic final_report();
		if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		#200us;
		error_cnt++;
		final_report();
	end
	// ==================================================
	// Stimulus
	// ==================================================
	// Every persistence and FIFO code, zero threshold every eighth round, one mid-run reset
	initial begin
		void'($urandom(32'hB25A));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 48; i++) begin
			i_host.write(1'b0, (i % 8 == 7) ? 8'h00 : 8'($urandom_range(1, 255)));
			// Fixed masks in some rounds so clear, west-south and all-masked cases surely occur
			msk = (i % 16 == 1) ? 4'h0 : (i % 16 == 5) ? 4'h6 : (i % 16 == 13) ? 4'hF : 4'($urandom);
			i_host.write(1'b1, {2'(i >> 2), msk, 2'(i)});
			quiet = (i % 3 != 0);
			if (i == 24) begin
				rstn <= 1'b0;
				@(posedge clk);
				rstn <= 1'b1;
			end
			repeat (80) begin
				@(posedge clk);
				mode <= ($urandom_range(0, 15) != 0);
				entry_req <= 1'($urandom);
				sample_valid <= ($urandom_range(0, 3) != 0);
				fifo_level <= 6'($urandom_range(0, 20));
				fifo_int_en <= ($urandom_range(0, 3) != 0);
				for (int k = 0; k < 4; k++)
					dir_data[8*k +: 8] <= quiet ? 8'($urandom_range(0, 40)) : 8'($urandom);
			end
		end
		final_report();
	end
endmodule
